// ==== smppd_prg.sv ====
`timescale 1ns/1ps
`include "smppd_regs.svh"
module smppd_fifo #(
  parameter int W = 32,
  parameter int D = 8
)
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          rdy_q;
  logic          vld_q;

  wire           push  = in_valid & rdy_q;
  wire           pop   = out_ready & vld_q;
  wire [CW-1:0]  cnt_d = cnt_q + CW'(push) - CW'(pop);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
    end
    else
    begin
      wp_q  <= push ? AW'((wp_q + 1'b1) % D) : wp_q;
      rp_q  <= pop ? AW'((rp_q + 1'b1) % D) : rp_q;
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != CW'(D));
      vld_q <= (cnt_d != '0);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  assign in_ready  = rdy_q;
  assign out_valid = vld_q;
  assign out_data  = mem[rp_q];

endmodule : smppd_fifo

module smppd_prg
  import smppd_pkg::*;
#(
  parameter int PWRUP_CYC = int'(`SMPP_T_PWRUP_MS * 1.0e6 / `SMPP_CLK_NS)
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  smppd_if.prg             lnk,
  input  wire logic        sess_en,
  input  wire logic        cmd_valid,
  input  wire logic [31:0] cmd_data,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_data,
  output logic             session_up
);

  localparam logic [31:0] PEN_WORD  = {`SMPP_OP_PEN, `SMPP_PEN_B2, 16'h0000};
  localparam logic [31:0] POLL_WORD = {`SMPP_OP_POLL, 24'h00_0000};

  smppd_hst_t  hst_q;
  smppd_kind_t kind_q;
  smppd_kind_t start_kind;
  logic [31:0] ph_q;
  logic [4:0]  bit_q;
  logic [31:0] sh_q;
  logic [31:0] cur_q;
  logic [31:0] rx_q;
  logic [31:0] rsp_q;
  logic [1:0]  sdo_sq;
  logic        sck_q;
  logic        sdi_q;
  logic        rstn_q;
  logic        up_q;
  logic        rsp_valid_q;
  logic        f_valid;
  logic [31:0] f_data;
  logic [31:0] start_word;
  logic        f_take;

  // ----------------------------------------------------------------
  // command queue
  // ----------------------------------------------------------------
  smppd_fifo #(
    .W (32),
    .D (8)
  ) smppd_fifo_i (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (cmd_valid),
    .in_data   (cmd_data),
    .in_ready  (cmd_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_take)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
      sdo_sq <= '0;
    else
      sdo_sq <= {sdo_sq[0], lnk.prog_serial_out};
  end

  // ----------------------------------------------------------------
  // sequencing decode
  // ----------------------------------------------------------------
  wire ph_zero  = (ph_q == '0);
  wire last     = (bit_q == `SMPP_LAST_BIT);
  wire fin      = (hst_q == H_SHIFT) & sck_q & ph_zero & last;
  wire echo_ok  = (rx_q[15:8] == `SMPP_PEN_B2);
  wire wr_class = (cur_q[31:24] == `SMPP_OP_WREE) | (cur_q[31:24] == `SMPP_OP_WRPG) |
                  ((cur_q[31:24] == `SMPP_OP_PEN) & (cur_q[23:21] == `SMPP_ERASE_B2));
  assign f_take = (hst_q == H_IDLE) & sess_en & f_valid;
  wire go_pen   = ((hst_q == H_WAIT) | (hst_q == H_PULSE)) & ph_zero;
  wire go_poll  = fin & (((kind_q == K_USR) & wr_class) |
                         ((kind_q == K_POLL) & rx_q[0]));
  wire start_go = go_pen | go_poll | f_take;
  wire retry    = (kind_q == K_EN) & ~echo_ok;

  assign start_kind = f_take ? K_USR : go_poll ? K_POLL : K_EN;
  assign start_word = f_take ? f_data : go_poll ? POLL_WORD : PEN_WORD;

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hst_q       <= H_OFF;
      kind_q      <= K_EN;
      ph_q        <= '0;
      bit_q       <= '0;
      sh_q        <= '0;
      cur_q       <= '0;
      rx_q        <= '0;
      rsp_q       <= '0;
      sck_q       <= 1'b0;
      sdi_q       <= 1'b0;
      rstn_q      <= 1'b1;
      up_q        <= 1'b0;
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= fin & (kind_q == K_USR);
      if (fin & (kind_q == K_USR))
        rsp_q <= rx_q;
      if (start_go)
      begin
        hst_q  <= H_SHIFT;
        kind_q <= start_kind;
        cur_q  <= start_word;
        sh_q   <= {start_word[30:0], 1'b0};
        sdi_q  <= start_word[31];
        bit_q  <= '0;
        ph_q   <= 32'(`SMPP_SCK_HALF - 1);
        sck_q  <= 1'b0;
        rstn_q <= 1'b0;
      end
      else
      begin
        unique case (hst_q)
          H_OFF:
          begin
            sck_q <= 1'b0;
            if (sess_en)
            begin
              rstn_q <= 1'b0;
              ph_q   <= 32'(PWRUP_CYC);
              hst_q  <= H_WAIT;
            end
          end
          H_WAIT,
          H_PULSE:
            ph_q <= ph_q - 32'h0000_0001;
          H_IDLE:
          begin
            if (~sess_en)
            begin
              hst_q  <= H_OFF;
              rstn_q <= 1'b1;
              up_q   <= 1'b0;
            end
          end
          H_SHIFT:
          begin
            if (~ph_zero)
              ph_q <= ph_q - 32'h0000_0001;
            else if (~sck_q)
            begin
              rx_q  <= {rx_q[30:0], sdo_sq[1]};
              sck_q <= 1'b1;
              ph_q  <= 32'(`SMPP_SCK_HALF - 1);
            end
            else if (last)
            begin
              sck_q  <= 1'b0;
              hst_q  <= retry ? H_PULSE : H_IDLE;
              rstn_q <= retry;
              ph_q   <= 32'(`SMPP_RST_PULSE - 1);
              up_q   <= up_q | ((kind_q == K_EN) & echo_ok);
            end
            else
            begin
              sck_q <= 1'b0;
              sdi_q <= sh_q[31];
              sh_q  <= {sh_q[30:0], 1'b0};
              bit_q <= bit_q + 5'h01;
              ph_q  <= 32'(`SMPP_SCK_HALF - 1);
            end
          end
          default:
            hst_q <= H_OFF;
        endcase
      end
    end
  end

  assign lnk.sck            = sck_q;
  assign lnk.prog_serial_in = sdi_q;
  assign lnk.prog_reset_n   = rstn_q;
  assign rsp_valid          = rsp_valid_q;
  assign rsp_data           = rsp_q;
  assign session_up         = up_q;

endmodule : smppd_prg

// ==== smppd_regs.svh ====
`ifndef SMPPD_REGS_SVH
`define SMPPD_REGS_SVH
// Functional notes
// - program/erase only under reset after enable
// - sample input on rise, shift output on fall
// - clock phases at least three cycles each
// - clock low, then reset pulse two cycles
// - wait 20ms at power-up before enable
// - echo 0x53 in byte three; always four bytes
// - missing echo: reset pulse, resend enable
// - four-byte instructions; enable is AC 53
// - chip erase clears program and data arrays
// - erased locations read 0xFF
// - data byte write self-timed, auto-erases
// - page buffer loaded bytewise, low before high
// - page write uses bits 15..7 plus extended
// - extended address byte held until reissued
// - wait 4.5ms after page write unless polling
// - data bytes one per instruction, 9.0ms apart
// - wait 9.0ms after erase unless polling
// - program read returns selected byte fourth
// - data read returns byte in fourth byte
// - erased data locations need no 0xFF writes
// - reset high leaves programming mode
// - poll returns busy as last bit

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define SMPP_OP_PEN    8'hAC
`define SMPP_PEN_B2    8'h53
`define SMPP_ERASE_B2  3'h4
`define SMPP_OP_LDEXT  8'h4D
`define SMPP_OP_RDFL   8'h20
`define SMPP_OP_LDPG   8'h40
`define SMPP_OP_WRPG   8'h4C
`define SMPP_OP_RDEE   8'hA0
`define SMPP_OP_WREE   8'hC0
`define SMPP_OP_POLL   8'hF0
`define SMPP_H_MASK    8'hF7
`define SMPP_H_BIT     3
`define SMPP_ERASED    8'hFF

// ----------------------------------------------------------------
// geometry and bit positions
// ----------------------------------------------------------------
`define SMPP_FL_AW     16
`define SMPP_EE_AW     12
`define SMPP_PG_AW     7
`define SMPP_FL_LAST   16'hFFFF
`define SMPP_PG_LAST   7'h7F
`define SMPP_LAST_BIT  5'h1F
`define SMPP_B3_LAST   5'h17
`define SMPP_BYTE_LAST 3'h7
`define SMPP_WAIT_W    24

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SMPP_CLK_NS       5.0
`define SMPP_T_FLASH_MS   4.5
`define SMPP_T_EE_MS      9.0
`define SMPP_T_ERASE_MS   9.0
`define SMPP_T_PWRUP_MS   20.0
`define SMPP_SCK_MIN_PH   3
`define SMPP_SCK_HALF     12
`define SMPP_RST_PULSE    8

`endif

// ==== smppd_pkg.sv ====
package smppd_pkg;

  typedef enum logic [1:0] {
    D_IDLE  = 2'b00,
    D_ERASE = 2'b01,
    D_PAGE  = 2'b10,
    D_WAIT  = 2'b11
  } smppd_dop_t;

  typedef enum logic [2:0] {
    H_OFF   = 3'b000,
    H_WAIT  = 3'b001,
    H_PULSE = 3'b010,
    H_IDLE  = 3'b011,
    H_SHIFT = 3'b100
  } smppd_hst_t;

  typedef enum logic [1:0] {
    K_EN   = 2'b00,
    K_USR  = 2'b01,
    K_POLL = 2'b10
  } smppd_kind_t;

endpackage : smppd_pkg

// ==== smppd_if.sv ====
`timescale 1ns/1ps
interface smppd_if;
  logic prog_reset_n;
  logic sck;
  logic prog_serial_in;
  logic prog_serial_out;

  modport dev (
    input  prog_reset_n,
    input  sck,
    input  prog_serial_in,
    output prog_serial_out
  );

  modport prg (
    output prog_reset_n,
    output sck,
    output prog_serial_in,
    input  prog_serial_out
  );
endinterface : smppd_if

// ==== smppd_dev.sv ====
`timescale 1ns/1ps
`include "smppd_regs.svh"
module smppd_dev
  import smppd_pkg::*;
#(
  parameter int FLASH_WAIT_CYC = int'(`SMPP_T_FLASH_MS * 1.0e6 / `SMPP_CLK_NS),
  parameter int EE_WAIT_CYC    = int'(`SMPP_T_EE_MS * 1.0e6 / `SMPP_CLK_NS),
  parameter int ERASE_WAIT_CYC = int'(`SMPP_T_ERASE_MS * 1.0e6 / `SMPP_CLK_NS)
)
(
  input  wire logic clk,
  input  wire logic srst,
  smppd_if.dev      lnk,
  output logic      run_mode,
  output logic      busy
);

  logic [2:0]               sck_sq;
  logic [1:0]               sdi_sq;
  logic [1:0]               rstn_sq;
  logic [31:0]              rx_q;
  logic [4:0]               bit_q;
  logic [7:0]               tx_q;
  logic                     sdo_q;
  logic                     en_q;
  logic                     run_q;
  logic [7:0]               ext_q;
  logic                     busy_q;
  smppd_dop_t               dop_q;
  smppd_dop_t               dop_d;
  logic [`SMPP_FL_AW-1:0]   cnt_q;
  logic [`SMPP_WAIT_W-1:0]  wait_q;
  logic [8:0]               pg_base_q;
  logic [15:0]              flash_mem [0:(1<<`SMPP_FL_AW)-1];
  logic [7:0]               ee_mem    [0:(1<<`SMPP_EE_AW)-1];
  logic [15:0]              pg_mem    [0:(1<<`SMPP_PG_AW)-1];

  // ----------------------------------------------------------------
  // link synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sck_sq  <= '0;
      sdi_sq  <= '0;
      rstn_sq <= '1;
    end
    else
    begin
      sck_sq  <= {sck_sq[1:0], lnk.sck};
      sdi_sq  <= {sdi_sq[0], lnk.prog_serial_in};
      rstn_sq <= {rstn_sq[0], lnk.prog_reset_n};
    end
  end

  wire sck_rise = sck_sq[1] & ~sck_sq[2];
  wire sck_fall = ~sck_sq[1] & sck_sq[2];
  wire in_prog  = ~rstn_sq[1];

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire [31:0] rx_d     = {rx_q[30:0], sdi_sq[1]};
  wire        byte_end = sck_rise & (bit_q[2:0] == `SMPP_BYTE_LAST);
  wire        b3_end   = sck_rise & (bit_q == `SMPP_B3_LAST);
  wire        done     = sck_rise & (bit_q == `SMPP_LAST_BIT);

  wire [7:0]  e_b1 = rx_d[23:16];
  wire [7:0]  e_b2 = rx_d[15:8];
  wire [7:0]  e_b3 = rx_d[7:0];
  wire [7:0]  b1   = rx_d[31:24];
  wire [7:0]  b2   = rx_d[23:16];
  wire [7:0]  b3   = rx_d[15:8];
  wire [7:0]  b4   = rx_d[7:0];
  wire        hsel = b1[`SMPP_H_BIT];

  wire ext_ok  = (ext_q == 8'h00);
  wire e_rdfl  = (e_b1 & `SMPP_H_MASK) == `SMPP_OP_RDFL;
  wire e_rdee  = (e_b1 == `SMPP_OP_RDEE);
  wire e_poll  = (e_b1 == `SMPP_OP_POLL);
  wire is_pen  = (b1 == `SMPP_OP_PEN) & (b2 == `SMPP_PEN_B2);
  wire accept  = done & en_q & in_prog & ~busy_q;
  wire do_erase = accept & (b1 == `SMPP_OP_PEN) & (b2[7:5] == `SMPP_ERASE_B2);
  wire do_ldext = accept & (b1 == `SMPP_OP_LDEXT);
  wire do_ldpg  = accept & ((b1 & `SMPP_H_MASK) == `SMPP_OP_LDPG);
  wire do_wrpg  = accept & (b1 == `SMPP_OP_WRPG);
  wire do_wree  = accept & (b1 == `SMPP_OP_WREE);

  // ----------------------------------------------------------------
  // read data for the fourth byte
  // ----------------------------------------------------------------
  wire [15:0] rd_word  = flash_mem[{e_b2, e_b3}];
  wire [7:0]  rd_half  = e_b1[`SMPP_H_BIT] ? rd_word[15:8] : rd_word[7:0];
  wire [7:0]  rd_flash = ext_ok ? rd_half : `SMPP_ERASED;
  wire [7:0]  rd_ee    = ee_mem[{e_b2[3:0], e_b3}];
  wire        rd_en    = b3_end & en_q;
  wire [7:0]  tx_load  = (rd_en & e_rdfl) ? rd_flash :
                         (rd_en & e_rdee) ? rd_ee :
                         (rd_en & e_poll) ? {7'h00, busy_q} :
                         rx_d[7:0];

  // ----------------------------------------------------------------
  // serial shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst | ~in_prog)
    begin
      rx_q  <= '0;
      bit_q <= '0;
      tx_q  <= '0;
      sdo_q <= 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        rx_q  <= rx_d;
        bit_q <= bit_q + 5'h01;
      end
      if (byte_end)
        tx_q <= tx_load;
      else if (sck_fall)
      begin
        sdo_q <= tx_q[7];
        tx_q  <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign lnk.prog_serial_out = sdo_q;

  // ----------------------------------------------------------------
  // programming mode and extended address
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      en_q  <= 1'b0;
      run_q <= 1'b0;
      ext_q <= 8'h00;
    end
    else
    begin
      run_q <= ~in_prog;
      if (~in_prog)
        en_q <= 1'b0;
      else if (done & is_pen)
        en_q <= 1'b1;
      if (do_ldext)
        ext_q <= b3;
    end
  end

  assign run_mode = run_q;
  assign busy     = busy_q;

  // ----------------------------------------------------------------
  // self-timed operations
  // ----------------------------------------------------------------
  wire walking = (dop_q == D_ERASE) | (dop_q == D_PAGE);
  wire cnt_end = (dop_q == D_ERASE) ? (cnt_q == `SMPP_FL_LAST)
                                    : (cnt_q[`SMPP_PG_AW-1:0] == `SMPP_PG_LAST);

  always_comb
  begin
    dop_d = dop_q;
    unique case (dop_q)
      D_IDLE:
      begin
        if (do_erase)
          dop_d = D_ERASE;
        else if (do_wrpg)
          dop_d = D_PAGE;
        else if (do_wree)
          dop_d = D_WAIT;
      end
      D_ERASE,
      D_PAGE:
      begin
        if (cnt_end)
          dop_d = D_WAIT;
      end
      D_WAIT:
      begin
        if (wait_q == '0)
          dop_d = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dop_q     <= D_IDLE;
      busy_q    <= 1'b0;
      cnt_q     <= '0;
      wait_q    <= '0;
      pg_base_q <= '0;
    end
    else
    begin
      dop_q  <= dop_d;
      busy_q <= (dop_d != D_IDLE);
      cnt_q  <= walking ? cnt_q + 16'h0001 : '0;
      if (do_erase)
        wait_q <= `SMPP_WAIT_W'(ERASE_WAIT_CYC);
      else if (do_wrpg)
        wait_q <= `SMPP_WAIT_W'(FLASH_WAIT_CYC);
      else if (do_wree)
        wait_q <= `SMPP_WAIT_W'(EE_WAIT_CYC);
      else if ((dop_q != D_IDLE) && (wait_q != '0))
        wait_q <= wait_q - 24'h00_0001;
      if (do_wrpg)
        pg_base_q <= {b2, b3[7]};
    end
  end

  // ----------------------------------------------------------------
  // memory arrays
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (dop_q == D_ERASE)
    begin
      flash_mem[cnt_q] <= {`SMPP_ERASED, `SMPP_ERASED};
      ee_mem[cnt_q[`SMPP_EE_AW-1:0]] <= `SMPP_ERASED;
    end
    else if ((dop_q == D_PAGE) & ext_ok)
      flash_mem[{pg_base_q, cnt_q[`SMPP_PG_AW-1:0]}] <=
        pg_mem[cnt_q[`SMPP_PG_AW-1:0]];
    if (do_wree)
      ee_mem[{b2[3:0], b3}] <= b4;
  end

  always_ff @(posedge clk)
  begin
    if (do_ldpg & hsel)
      pg_mem[b3[`SMPP_PG_AW-1:0]][15:8] <= b4;
    else if (do_ldpg)
      pg_mem[b3[`SMPP_PG_AW-1:0]][7:0] <= b4;
  end

endmodule : smppd_dev

// ==== smppd_monitor.sv ====
`timescale 1ns/1ps
module smppd_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic prog_serial_in,
  input wire logic prog_serial_out,
  input wire logic run_mode,
  input wire logic busy,
  input wire logic session_up
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ----------
  // sequences
  // ----------
  sequence s_sck_hi;
    sck [*3];
  endsequence
  sequence s_sck_lo;
    !sck [*3];
  endsequence
  sequence s_pulse;
    prog_reset_n [*2];
  endsequence
  sequence s_in_session_change;
    !prog_reset_n [*6] ##0 $changed(prog_serial_out);
  endsequence

  // ----------
  // assertions
  // ----------
  sck_high_min_a: assert property ($rose(sck) |-> s_sck_hi)
    else $error("link clock high phase too short");
  sck_low_min_a: assert property ($fell(sck) |-> s_sck_lo)
    else $error("link clock low phase too short");
  reset_pulse_a: assert property ($rose(prog_reset_n) |-> s_pulse)
    else $error("reset pulse shorter than two cycles");
  pulse_clk_low_a: assert property ($rose(prog_reset_n) |-> !sck)
    else $error("reset pulse with link clock high");
  run_on_a: assert property (prog_reset_n [*5] |-> run_mode)
    else $error("normal run not resumed");
  run_off_a: assert property (!prog_reset_n [*5] |-> !run_mode)
    else $error("normal run while reset pin low");
  out_on_fall_a: assert property (s_in_session_change |->
    !$past(sck, 2) && !$past(sck, 3) && $past(sck, 6))
    else $error("serial out changed away from clock fall");
  in_on_low_a: assert property ($changed(prog_serial_in) |-> !sck)
    else $error("serial in changed while clock high");
  busy_start_a: assert property ($rose(busy) |-> !prog_reset_n)
    else $error("write started outside programming mode");
  session_a: assert property ($rose(session_up) |-> !prog_reset_n)
    else $error("session up outside programming mode");
endmodule : smppd_monitor

// ==== smppd_tb.sv ====
`timescale 1ns/1ps
module smppd_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        sess_en = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [31:0] cmd_data = 32'h0000_0000;
  logic        cmd_ready, rsp_valid, session_up, run_mode, busy;
  logic [31:0] rsp_data;
  int          failures = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  smppd_if smppd_if_i ();
  smppd_dev #(.FLASH_WAIT_CYC(200), .EE_WAIT_CYC(200), .ERASE_WAIT_CYC(66000)) smppd_dev_i (
    .clk(clk), .srst(srst), .lnk(smppd_if_i.dev), .run_mode(run_mode), .busy(busy));
  smppd_prg #(.PWRUP_CYC(50)) smppd_prg_i (
    .clk(clk), .srst(srst), .lnk(smppd_if_i.prg), .sess_en(sess_en),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .session_up(session_up));
  smppd_monitor smppd_monitor_i (
    .clk(clk), .srst(srst), .prog_reset_n(smppd_if_i.prog_reset_n), .sck(smppd_if_i.sck),
    .prog_serial_in(smppd_if_i.prog_serial_in), .prog_serial_out(smppd_if_i.prog_serial_out),
    .run_mode(run_mode), .busy(busy), .session_up(session_up));

  // ----------
  // tasks
  // ----------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic push(input logic [31:0] c);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_data = c;
    for (int n = 0; n < 200000 && cmd_ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : push

  task automatic getr(output logic [31:0] d);
    for (int n = 0; n < 200000 && rsp_valid !== 1'b1; n++) @(negedge clk);
    d = rsp_data;
    @(negedge clk);
  endtask : getr

  task automatic xfer(input logic [31:0] c, output logic [31:0] d);
    push(c);
    getr(d);
    check({16'h0000, d[23:8]}, {16'h0000, c[31:16]});
  endtask : xfer

  task automatic rd(input logic [31:0] c, input logic [7:0] e);
    logic [31:0] d;
    xfer(c, d);
    check({24'h0, d[7:0]}, {24'h0, e});
  endtask : rd

  // ----------
  // scenarios
  // ----------
  task automatic t_enable;
    @(negedge clk);
    sess_en = 1'b1;
    for (int n = 0; n < 5000 && session_up !== 1'b1; n++) @(negedge clk);
    check({31'h0, session_up}, 32'h0000_0001);
    check({31'h0, run_mode}, 32'h0000_0000);
  endtask : t_enable

  task automatic t_erase;
    logic [31:0] d;
    xfer(32'h4D00_0000, d);
    xfer(32'hAC80_0000, d);
    check({31'h0, busy}, 32'h0000_0001);
    rd(32'h2000_0000, 8'hFF);
    rd(32'h28FF_FF00, 8'hFF);
    rd(32'hA00F_FF00, 8'hFF);
    rd(32'hA001_2300, 8'hFF);
  endtask : t_erase

  task automatic t_page;
    logic [31:0] d;
    xfer(32'h4000_05A5, d);
    xfer(32'h4800_055A, d);
    xfer(32'h4000_7F11, d);
    xfer(32'h4C01_0000, d);
    rd(32'h2001_0500, 8'hA5);
    rd(32'h2801_0500, 8'h5A);
    rd(32'h2001_7F00, 8'h11);
    rd(32'h2001_8500, 8'hFF);
  endtask : t_page

  task automatic t_ext;
    logic [31:0] d;
    xfer(32'h4D00_0100, d);
    rd(32'h2001_0500, 8'hFF);
    xfer(32'h4D00_0000, d);
    rd(32'h2001_0500, 8'hA5);
  endtask : t_ext

  task automatic t_eeprom;
    logic [31:0] d;
    xfer(32'hC001_233C, d);
    rd(32'hA001_2300, 8'h3C);
    xfer(32'hC001_23C3, d);
    rd(32'hA001_2300, 8'hC3);
    rd(32'hF000_0000, 8'h00);
  endtask : t_eeprom

  task automatic t_fifo;
    logic [31:0] d;
    @(negedge clk);
    sess_en = 1'b0;
    for (int n = 0; n < 100 && run_mode !== 1'b1; n++) @(negedge clk);
    check({31'h0, run_mode}, 32'h0000_0001);
    check({31'h0, session_up}, 32'h0000_0000);
    for (int i = 0; i < 8; i++) push(32'hA001_2300);
    check({31'h0, cmd_ready}, 32'h0000_0000);
    sess_en = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      getr(d);
      check({24'h0, d[7:0]}, 32'h0000_00C3);
    end
  endtask : t_fifo

  // ----------
  // main
  // ----------
  initial
  begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    t_enable;
    t_erase;
    t_page;
    t_ext;
    t_eeprom;
    t_fifo;
    report_and_stop;
  end

  initial
  begin
    repeat (110000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule : smppd_tb
